// [logic/power_down_pin_state_ctrl.sv]
// Power-down entry and exit control, and pin states in the power-saving modes.
// Assumes CPU, bus controller and ports drive the live inputs on this clock;
// the two pins arrive asynchronously.
//
// How it works
// - Power-down stops all clocks, RTC optional, RAM kept
// - Watchdog halted throughout power-down
// - Only reset pin low leaves power-down
// - Pin reset restores registers and ports, not RAM
// - Power-down command is protected 32-bit word
// - Command acts only with NMI pin low
// - Enter only after the command completes
// - Watchdog word flags power-on versus power-down restart
// - Control field can stop RTC, tristate pins
// - Field codes: 00 on, 01 ports off, 10, 11
// - Pins configured as input are not driven
// - No address window enabled releases external bus
// - Idle: latch outputs kept, alternate outputs live
// - Sleep: latch outputs kept, alternate outputs frozen
// - Power-down: latch outputs kept, alternate outputs frozen
// - Strobes inactive, byte-high-enable keeps last value
// - Low byte floats; high byte address if mux8
// - Demux mode keeps last 16 address bits
// - Segment lines keep last segment address
// - Last chip select low; extension access clears all
// - Clock out toggles in idle, else high/held
// - Reset output high only after end of initialization
// - External bus actions finish before entry
`timescale 1ns/1ps
`include "pdn_defs.svh"

module power_down_pin_state_ctrl (
	input wire logic clock,
	input wire logic rst,
	input wire logic nmi_pin_n,
	input wire logic hardware_reset_input_n,
	input wire logic instr_valid,
	input wire logic [31:0] instr_word,
	input wire logic instr_done,
	input wire logic [1:0] sleep_mode_cfg,
	input wire logic wake_irq,
	input wire logic bus_busy,
	input wire logic ext_access,
	input wire logic xper_access,
	input wire logic [15:0] live_addr,
	input wire logic [7:0] live_seg,
	input wire pdn_pkg::bus_ctrl_s live_bus,
	input wire pdn_pkg::bus_cfg_s bus_cfg,
	input wire pdn_pkg::pin_bank_s live_val,
	input wire pdn_pkg::pin_bank_s live_oe_n,
	input wire pdn_pkg::pin_bank_s latch_val,
	input wire pdn_pkg::pin_bank_s dir_in,
	input wire logic [15:0] alt_sel,
	input wire logic live_system_clock_output,
	input wire logic live_programmable_frequency_output,
	input wire logic sys2_we,
	input wire logic [1:0] sys2_power_down_pin_rtc_control,
	input wire logic end_of_initialization_pulse,
	input wire logic flag_clear,
	output pdn_pkg::mode_e mode,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic watchdog_run,
	output logic rtc_run,
	output logic osc_run,
	output logic sfr_port_reset,
	output logic [1:0] power_down_pin_rtc_control,
	output logic [15:0] watchdog_control_reg,
	output pdn_pkg::pin_bank_s pin_out,
	output pdn_pkg::pin_bank_s pin_oe_n,
	output pdn_pkg::bus_ctrl_s bus_pins,
	output logic ctrl_oe_n,
	output logic system_clock_output,
	output logic programmable_frequency_output,
	output logic reset_output_pin
);

	pdn_pkg::mode_e state_reg;
	pdn_pkg::mode_e state_next;
	pdn_pkg::mode_e target_reg;
	logic nmi_level;
	logic reset_pin_ok;
	logic nmi_prev_reg;
	logic done_reg;
	logic pd_hit;
	logic idle_hit;
	logic saving;
	logic stopped;
	logic ext_bus;
	logic [1:0] power_down_pin_rtc_control_reg;
	logic end_of_initialization_reg;
	logic [2:0] flags_reg;
	logic [15:0] last_addr_reg;
	logic [7:0] last_seg_reg;
	logic last_bhe_n_reg;
	logic [`PDN_CS_LINES-1:0] last_cs_n_reg;
	logic [15:0] frz_val_reg;
	logic [15:0] frz_oe_n_reg;
	logic frz_programmable_frequency_output_reg;
	pdn_pkg::pin_bank_s out_next;
	pdn_pkg::pin_bank_s oe_n_next;
	pdn_pkg::bus_ctrl_s bus_next;
	logic ctrl_oe_n_next;
	logic system_clock_output_next;
	logic programmable_frequency_output_next;
	pdn_pkg::pin_bank_s out_reg;
	pdn_pkg::pin_bank_s oe_n_reg;
	pdn_pkg::bus_ctrl_s bus_reg;
	logic ctrl_oe_n_reg;
	logic system_clock_output_reg;
	logic programmable_frequency_output_reg;

	// Protected 32-bit encoding: opcode low, its inverse high
	function automatic logic is_protected(input logic [31:0] w, input logic [15:0] op);
		return (w[15:0] == op) && (w[31:16] == ~op);
	endfunction

	// Pins from outside the clock domain
	pin_sync #(.W(2)) pin_sync_i (
		.clock(clock),
		.rst(rst),
		.pin_in({nmi_pin_n, hardware_reset_input_n}),
		.level_out({nmi_level, reset_pin_ok})
	);

	// Instruction decode; a stray single word never matches
	assign pd_hit = instr_valid && is_protected(instr_word, `PDN_POWER_DOWN_OPCODE)
		&& !nmi_level;
	assign idle_hit = instr_valid && is_protected(instr_word, `PDN_IDLE_OPCODE);
	assign saving = (state_reg == pdn_pkg::MODE_IDLE) || stopped;
	assign stopped = (state_reg == pdn_pkg::MODE_SLEEP) || (state_reg == pdn_pkg::MODE_PDOWN);
	assign ext_bus = |bus_cfg.window_en;

	// Mode sequencing
	always_comb begin
		state_next = state_reg;
		if (!reset_pin_ok) begin
			state_next = pdn_pkg::MODE_ACTIVE;
		end else begin
			unique case (state_reg)
				pdn_pkg::MODE_ACTIVE: begin
					if (pd_hit || idle_hit) begin
						state_next = pdn_pkg::MODE_DRAIN;
					end
				end
				pdn_pkg::MODE_DRAIN: begin
					if ((done_reg || instr_done) && !bus_busy) begin
						state_next = target_reg;
					end
				end
				pdn_pkg::MODE_IDLE: begin
					if (wake_irq || (nmi_prev_reg && !nmi_level)) begin
						state_next = pdn_pkg::MODE_ACTIVE;
					end
				end
				pdn_pkg::MODE_SLEEP: begin
					if (wake_irq) begin
						state_next = pdn_pkg::MODE_ACTIVE;
					end
				end
				pdn_pkg::MODE_PDOWN: begin
					state_next = pdn_pkg::MODE_PDOWN;
				end
				default: begin
					state_next = pdn_pkg::MODE_ACTIVE;
				end
			endcase
		end
	end

	// Mode register
	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= pdn_pkg::MODE_ACTIVE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Target mode chosen by the decoded instruction
	always_ff @(posedge clock) begin
		if (rst) begin
			target_reg <= pdn_pkg::MODE_IDLE;
		end else if (state_reg == pdn_pkg::MODE_ACTIVE) begin
			if (pd_hit) begin
				target_reg <= pdn_pkg::MODE_PDOWN;
			end else if (sleep_mode_cfg == `PDN_SLEEPCFG_IDLE
				|| sleep_mode_cfg == `PDN_SLEEPCFG_RSVD) begin
				target_reg <= pdn_pkg::MODE_IDLE;
			end else begin
				target_reg <= pdn_pkg::MODE_SLEEP;
			end
		end
	end

	// Completion of the requesting instruction, and NMI edge history
	always_ff @(posedge clock) begin
		if (rst) begin
			done_reg <= 1'b0;
			nmi_prev_reg <= 1'b1;
		end else begin
			nmi_prev_reg <= nmi_level;
			if (state_reg != pdn_pkg::MODE_DRAIN) begin
				done_reg <= 1'b0;
			end else if (instr_done) begin
				done_reg <= 1'b1;
			end
		end
	end

	// Clock gating per mode; RAM sits on supply only, nothing here touches it
	assign cpu_clk_en = !saving;
	assign periph_clk_en = !stopped;
	assign watchdog_run = !stopped;
	always_comb begin
		rtc_run = 1'b1;
		if (state_reg == pdn_pkg::MODE_PDOWN) begin
			rtc_run = !power_down_pin_rtc_control_reg[`PDN_POWER_DOWN_PIN_RTC_CONTROL_RTC_OFF_BIT];
		end else if (state_reg == pdn_pkg::MODE_SLEEP) begin
			rtc_run = (sleep_mode_cfg != `PDN_SLEEPCFG_DARK);
		end
	end
	assign osc_run = !stopped || rtc_run;

	// Power-down control field; the pin reset returns it to default
	always_ff @(posedge clock) begin
		if (rst || !reset_pin_ok) begin
			power_down_pin_rtc_control_reg <= `PDN_POWER_DOWN_PIN_RTC_CONTROL_RESET;
		end else if (sys2_we) begin
			power_down_pin_rtc_control_reg <= sys2_power_down_pin_rtc_control;
		end
	end

	// End-of-initialization seen since the last reset
	always_ff @(posedge clock) begin
		if (rst || !reset_pin_ok) begin
			end_of_initialization_reg <= 1'b0;
		end else if (end_of_initialization_pulse) begin
			end_of_initialization_reg <= 1'b1;
		end
	end

	// Reset identification flags; a set in the clear cycle wins
	always_ff @(posedge clock) begin
		if (rst) begin
			flags_reg <= 3'h4;
		end else begin
			if (flag_clear) begin
				flags_reg <= 3'h0;
			end
			if (!reset_pin_ok) begin
				flags_reg[`PDN_WDT_PIN_BIT-`PDN_WDT_PDN_BIT] <= 1'b1;
				if (state_reg == pdn_pkg::MODE_PDOWN) begin
					flags_reg[0] <= 1'b1;
				end
			end
		end
	end
	assign watchdog_control_reg = {11'h000, flags_reg, 2'h0};

	// Last external access; an extension access drops every chip select
	always_ff @(posedge clock) begin
		if (rst || !reset_pin_ok) begin
			last_addr_reg <= 16'h0000;
			last_seg_reg <= 8'h00;
			last_bhe_n_reg <= 1'b1;
			last_cs_n_reg <= '1;
		end else if (xper_access) begin
			last_cs_n_reg <= '1;
		end else if (ext_access) begin
			last_addr_reg <= live_addr;
			last_seg_reg <= live_seg;
			last_bhe_n_reg <= live_bus.bhe_n;
			last_cs_n_reg <= live_bus.cs_n;
		end
	end

	// Alternate-function outputs track the peripherals while they are clocked
	always_ff @(posedge clock) begin
		if (rst || !reset_pin_ok) begin
			frz_val_reg <= 16'h0000;
			frz_oe_n_reg <= 16'hffff;
			frz_programmable_frequency_output_reg <= 1'b0;
		end else if (!stopped) begin
			frz_val_reg <= live_val.gp;
			frz_oe_n_reg <= live_oe_n.gp;
			frz_programmable_frequency_output_reg <= live_programmable_frequency_output;
		end
	end

	// Pin values for the current mode
	always_comb begin
		out_next = live_val;
		oe_n_next = live_oe_n;
		bus_next = live_bus;
		ctrl_oe_n_next = 1'b0;
		system_clock_output_next = live_system_clock_output;
		programmable_frequency_output_next = live_programmable_frequency_output;
		if (saving) begin
			out_next = latch_val;
			oe_n_next = dir_in;
			if (stopped) begin
				out_next.gp = (alt_sel & frz_val_reg) | (~alt_sel & latch_val.gp);
				oe_n_next.gp = (alt_sel & frz_oe_n_reg) | (~alt_sel & dir_in.gp);
				system_clock_output_next = 1'b1;
				programmable_frequency_output_next = frz_programmable_frequency_output_reg;
			end else begin
				out_next.gp = (alt_sel & live_val.gp) | (~alt_sel & latch_val.gp);
				oe_n_next.gp = (alt_sel & live_oe_n.gp) | (~alt_sel & dir_in.gp);
			end
			bus_next.ale = 1'b0;
			bus_next.rd_n = 1'b1;
			bus_next.wr_n = 1'b1;
			if (ext_bus) begin
				oe_n_next.p0[7:0] = 8'hff;
				oe_n_next.p0[15:8] = bus_cfg.mux8 ? 8'h00 : 8'hff;
				out_next.p0[15:8] = last_addr_reg[15:8];
				if (bus_cfg.demux) begin
					out_next.p1 = last_addr_reg;
					oe_n_next.p1 = 16'h0000;
				end
				out_next.p4 = (bus_cfg.seg_sel & last_seg_reg)
					| (~bus_cfg.seg_sel & latch_val.p4);
				oe_n_next.p4 = ~bus_cfg.seg_sel & dir_in.p4;
				bus_next.bhe_n = last_bhe_n_reg;
				bus_next.cs_n = last_cs_n_reg;
			end
			if (state_reg == pdn_pkg::MODE_PDOWN && power_down_pin_rtc_control_reg[`PDN_POWER_DOWN_PIN_RTC_CONTROL_PORTS_OFF_BIT]) begin
				oe_n_next = '1;
				ctrl_oe_n_next = 1'b1;
			end
		end
	end

	// Registered pins; the pin reset forces port defaults
	always_ff @(posedge clock) begin
		if (rst || !reset_pin_ok) begin
			out_reg <= '0;
			oe_n_reg <= '1;
			bus_reg <= {1'b0, 1'b1, 1'b1, 1'b1, {`PDN_CS_LINES{1'b1}}};
			ctrl_oe_n_reg <= 1'b0;
			system_clock_output_reg <= 1'b1;
			programmable_frequency_output_reg <= 1'b0;
		end else begin
			out_reg <= out_next;
			oe_n_reg <= oe_n_next;
			bus_reg <= bus_next;
			ctrl_oe_n_reg <= ctrl_oe_n_next;
			system_clock_output_reg <= system_clock_output_next;
			programmable_frequency_output_reg <= programmable_frequency_output_next;
		end
	end

	assign mode = state_reg;
	assign sfr_port_reset = !reset_pin_ok;
	assign power_down_pin_rtc_control = power_down_pin_rtc_control_reg;
	assign pin_out = out_reg;
	assign pin_oe_n = oe_n_reg;
	assign bus_pins = bus_reg;
	assign ctrl_oe_n = ctrl_oe_n_reg;
	assign system_clock_output = system_clock_output_reg;
	assign programmable_frequency_output = programmable_frequency_output_reg;
	assign reset_output_pin = end_of_initialization_reg;

	// Checks on the sequencing and pin behaviour
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	sequence drain_to_pd;
		state_reg == pdn_pkg::MODE_DRAIN ##1 state_reg == pdn_pkg::MODE_PDOWN;
	endsequence

	sequence held_saving;
		saving ##1 saving;
	endsequence

	clocks_stopped_a: assert property (state_reg == pdn_pkg::MODE_PDOWN |->
		!cpu_clk_en && !periph_clk_en && rtc_run == !power_down_pin_rtc_control_reg[1])
		else $error("clocks running in power-down");
	watchdog_halt_a: assert property (state_reg == pdn_pkg::MODE_PDOWN |-> !watchdog_run)
		else $error("watchdog running in power-down");
	pd_exit_only_a: assert property (state_reg == pdn_pkg::MODE_PDOWN && reset_pin_ok
		|=> state_reg == pdn_pkg::MODE_PDOWN)
		else $error("power-down left without pin reset");
	pin_reset_a: assert property (!reset_pin_ok |=> state_reg == pdn_pkg::MODE_ACTIVE
		&& power_down_pin_rtc_control_reg == 2'h0 && pin_oe_n == '1 && !reset_output_pin)
		else $error("pin reset did not restore defaults");
	stray_word_a: assert property (state_reg == pdn_pkg::MODE_ACTIVE && reset_pin_ok
		&& !is_protected(instr_word, `PDN_POWER_DOWN_OPCODE)
		&& !is_protected(instr_word, `PDN_IDLE_OPCODE)
		|=> state_reg == pdn_pkg::MODE_ACTIVE)
		else $error("unprotected word started entry");
	nmi_gate_a: assert property (state_reg == pdn_pkg::MODE_ACTIVE && reset_pin_ok
		&& instr_valid && is_protected(instr_word, `PDN_POWER_DOWN_OPCODE) && nmi_level
		|=> state_reg == pdn_pkg::MODE_ACTIVE)
		else $error("power-down taken with NMI high");
	entry_done_a: assert property (drain_to_pd |->
		!$past(bus_busy) && ($past(done_reg) || $past(instr_done)))
		else $error("entry before completion or bus idle");
	pd_flag_a: assert property (state_reg == pdn_pkg::MODE_PDOWN && !reset_pin_ok
		|=> flags_reg[0] && flags_reg[1] && state_reg == pdn_pkg::MODE_ACTIVE)
		else $error("power-down restart not flagged");
	ports_off_a: assert property (state_reg == pdn_pkg::MODE_PDOWN && power_down_pin_rtc_control_reg[0]
		##1 state_reg == pdn_pkg::MODE_PDOWN |-> pin_oe_n == '1 && ctrl_oe_n)
		else $error("pins driven with ports off");
	strobes_idle_a: assert property (held_saving |->
		!bus_pins.ale && bus_pins.rd_n && bus_pins.wr_n)
		else $error("bus strobes active while saving");
	system_clock_output_high_a: assert property (stopped ##1 stopped |-> system_clock_output)
		else $error("clock output not high while stopped");

endmodule

// [logic/pdn_defs.svh]
// Constants for the power-down and pin state controller.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PDN_DEFS_SVH
`define PDN_DEFS_SVH

// Protected instruction layout: low half is the opcode, high half its inverse
`define PDN_POWER_DOWN_OPCODE 16'h28a5
`define PDN_IDLE_OPCODE 16'h2887

// Sleep mode configuration codes seen on the idle instruction
`define PDN_SLEEPCFG_IDLE 2'h0
`define PDN_SLEEPCFG_RSVD 2'h2
`define PDN_SLEEPCFG_DARK 2'h3

// Power-down pin and clock control field
`define PDN_POWER_DOWN_PIN_RTC_CONTROL_RESET 2'h0
`define PDN_POWER_DOWN_PIN_RTC_CONTROL_PORTS_OFF_BIT 0
`define PDN_POWER_DOWN_PIN_RTC_CONTROL_RTC_OFF_BIT 1

// Reset identification flags inside the watchdog control word
`define PDN_WDT_PDN_BIT 2
`define PDN_WDT_PIN_BIT 3
`define PDN_WDT_POR_BIT 4
`define PDN_WDT_CTRL_RESET 16'h0010

// Bus geometry
`define PDN_CS_LINES 5
`define PDN_WINDOWS 5

`endif

// [logic/pdn_pkg.sv]
// Types shared by the power-down and pin state controller.
// Assumes pdn_defs.svh is on the include path.
`include "pdn_defs.svh"

package pdn_pkg;

	// Operating modes of the device
	typedef enum logic [2:0] {
		MODE_ACTIVE = 3'b000,
		MODE_DRAIN = 3'b001,
		MODE_IDLE = 3'b010,
		MODE_SLEEP = 3'b011,
		MODE_PDOWN = 3'b100
	} mode_e;

	// External bus control pins
	typedef struct packed {
		logic ale;
		logic rd_n;
		logic wr_n;
		logic bhe_n;
		logic [`PDN_CS_LINES-1:0] cs_n;
	} bus_ctrl_s;

	// One value per port pin
	typedef struct packed {
		logic [15:0] p0;
		logic [15:0] p1;
		logic [7:0] p4;
		logic [15:0] gp;
	} pin_bank_s;

	// External bus configuration
	typedef struct packed {
		logic [`PDN_WINDOWS-1:0] window_en;
		logic mux8;
		logic demux;
		logic [7:0] seg_sel;
	} bus_cfg_s;

endpackage

// [logic/pin_sync.sv]
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes pins idle high; the output changes once stages two and three agree.
`timescale 1ns/1ps

module pin_sync #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level_out
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] level_reg;

	// Shift chain; only the second stage reads the first
	always_ff @(posedge clock) begin
		if (rst) begin
			s1_reg <= '1;
			s2_reg <= '1;
			s3_reg <= '1;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Accept a bit only where the last two stages agree
	always_ff @(posedge clock) begin
		if (rst) begin
			level_reg <= '1;
		end else begin
			level_reg <= (s2_reg & s3_reg) | (level_reg & (s2_reg ^ s3_reg));
		end
	end

	assign level_out = level_reg;

endmodule

// [tb/power_fail_model.sv]
// Model of the external power-fail circuit and the reset source.
// Assumes the bench raises fail and rst_req; the pins follow lag cycles later.
`timescale 1ns/1ps

module power_fail_model (
	input wire logic clock,
	input wire logic fail,
	input wire logic rst_req,
	input wire logic [3:0] lag,
	output logic nmi_pin_n,
	output logic reset_pin_n
);
	// Both lines rest high on their pull-ups
	initial begin
		nmi_pin_n = 1'b1;
		reset_pin_n = 1'b1;
	end

	// Power fail pulls the NMI line low and holds it while the fail lasts
	always @(fail) begin
		repeat (lag) @(posedge clock);
		nmi_pin_n <= !fail;
	end

	// Only this reset pulse may end power-down
	always @(rst_req) begin
		repeat (lag) @(posedge clock);
		reset_pin_n <= !rst_req;
	end
endmodule

// [tb/power_down_pin_state_ctrl_tb.sv]
// Self-checking bench for the power-down and pin state controller.
// Assumes the power-fail model drives both pins; inputs change at falling edges.
`timescale 1ns/1ps
`include "pdn_defs.svh"

module power_down_pin_state_ctrl_tb;
	localparam logic [31:0] pd_word = {~`PDN_POWER_DOWN_OPCODE, `PDN_POWER_DOWN_OPCODE};
	localparam logic [31:0] idle_word = {~`PDN_IDLE_OPCODE, `PDN_IDLE_OPCODE};
	logic clock, rst, nmi_pin_n, hardware_reset_input_n, instr_valid, instr_done;
	logic [31:0] instr_word;
	logic [1:0] sleep_mode_cfg, sys2_power_down_pin_rtc_control;
	logic wake_irq, bus_busy, ext_access, xper_access, live_system_clock_output, live_programmable_frequency_output;
	logic sys2_we, end_of_initialization_pulse, flag_clear, fail, rst_req;
	logic [15:0] live_addr, alt_sel;
	logic [7:0] live_seg;
	logic [3:0] lag;
	pdn_pkg::bus_ctrl_s live_bus, bus_pins;
	pdn_pkg::bus_cfg_s bus_cfg;
	pdn_pkg::pin_bank_s live_val, live_oe_n, latch_val, dir_in, pin_out, pin_oe_n;
	pdn_pkg::mode_e mode;
	logic cpu_clk_en, periph_clk_en, watchdog_run, rtc_run, osc_run, sfr_port_reset;
	logic [1:0] power_down_pin_rtc_control;
	logic [15:0] watchdog_control_reg;
	logic ctrl_oe_n, system_clock_output, programmable_frequency_output, reset_output_pin;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;

	power_down_pin_state_ctrl dut_u (.clock, .rst, .nmi_pin_n, .hardware_reset_input_n,
		.instr_valid, .instr_word, .instr_done, .sleep_mode_cfg, .wake_irq, .bus_busy,
		.ext_access, .xper_access, .live_addr, .live_seg, .live_bus, .bus_cfg, .live_val,
		.live_oe_n, .latch_val, .dir_in, .alt_sel, .live_system_clock_output, .live_programmable_frequency_output, .sys2_we,
		.sys2_power_down_pin_rtc_control, .end_of_initialization_pulse, .flag_clear, .mode, .cpu_clk_en, .periph_clk_en,
		.watchdog_run, .rtc_run, .osc_run, .sfr_port_reset, .power_down_pin_rtc_control,
		.watchdog_control_reg, .pin_out, .pin_oe_n, .bus_pins, .ctrl_oe_n,
		.system_clock_output, .programmable_frequency_output, .reset_output_pin);

	power_fail_model pf_u (.clock(clock), .fail(fail), .rst_req(rst_req), .lag(lag),
		.nmi_pin_n(nmi_pin_n), .reset_pin_n(hardware_reset_input_n));

	// System clock at 100 MHz
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Cuts a hung run short
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			n_fail++;
			give_verdict();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wait_mode(input pdn_pkg::mode_e m);
		for (int i = 0; i < 20 && mode !== m; i++) tick(1);
		chk("mode", mode, m);
	endtask

	// Instruction then its completion on the next cycle
	task automatic req(input logic [31:0] w);
		instr_valid = 1'b1;
		instr_word = w;
		tick(1);
		instr_valid = 1'b0;
		instr_done = 1'b1;
		tick(1);
		instr_done = 1'b0;
	endtask

	task automatic t_reset();
		chk("mode0", mode, pdn_pkg::MODE_ACTIVE);
		chk("pdcon0", power_down_pin_rtc_control, `PDN_POWER_DOWN_PIN_RTC_CONTROL_RESET);
		chk("wdt0", watchdog_control_reg, `PDN_WDT_CTRL_RESET);
		chk("rstout0", reset_output_pin, 1'b0);
	endtask

	task automatic t_refuse();
		req(pd_word);
		tick(4);
		chk("nmihigh", mode, pdn_pkg::MODE_ACTIVE);
		fail = 1'b1;
		tick(12);
		req({16'h0000, `PDN_POWER_DOWN_OPCODE});
		tick(4);
		chk("badword", mode, pdn_pkg::MODE_ACTIVE);
	endtask

	task automatic t_power_down_pin_rtc_control();
		for (int i = 0; i < 4; i++) begin
			sys2_we = 1'b1;
			sys2_power_down_pin_rtc_control = i[1:0];
			tick(1);
			chk("power_down_pin_rtc_control", power_down_pin_rtc_control, i[1:0]);
		end
		sys2_we = 1'b0;
	endtask

	task automatic t_pdown(input logic [1:0] pc);
		lag = pc[0] ? 4'h6 : 4'h1;
		sys2_we = 1'b1;
		sys2_power_down_pin_rtc_control = pc;
		tick(1);
		sys2_we = 1'b0;
		bus_busy = 1'b1;
		req(pd_word);
		tick(5);
		chk("drain", mode, pdn_pkg::MODE_DRAIN);
		bus_busy = 1'b0;
		wait_mode(pdn_pkg::MODE_PDOWN);
		tick(2);
		chk("cpu", cpu_clk_en, 1'b0);
		chk("wdog", watchdog_run, 1'b0);
		chk("rtc", rtc_run, !pc[1]);
		chk("osc", osc_run, !pc[1]);
		chk("strobes", {bus_pins.ale, bus_pins.rd_n, bus_pins.wr_n}, 3'h3);
		chk("clkhi", system_clock_output, 1'b1);
		if (pc[0]) chk("alloff", &{pin_oe_n, ctrl_oe_n}, 1'b1);
		else begin
			chk("gp", pin_out.gp, latch_val.gp);
			chk("p1latch", pin_out.p1, latch_val.p1);
		end
		wake_irq = 1'b1;
		tick(5);
		chk("stay", mode, pdn_pkg::MODE_PDOWN);
		wake_irq = 1'b0;
		rst_req = 1'b1;
		wait_mode(pdn_pkg::MODE_ACTIVE);
		tick(2);
		chk("sfrrst", sfr_port_reset, 1'b1);
		chk("pdconrst", power_down_pin_rtc_control, `PDN_POWER_DOWN_PIN_RTC_CONTROL_RESET);
		chk("flags", watchdog_control_reg[3:2], 2'h3);
		rst_req = 1'b0;
		tick(14);
		chk("sfrrel", sfr_port_reset, 1'b0);
		flag_clear = 1'b1;
		tick(1);
		flag_clear = 1'b0;
		tick(1);
		chk("flagclr", watchdog_control_reg, 16'h0000);
	endtask

	task automatic t_idle();
		bus_cfg = {5'h01, 1'b1, 1'b1, 8'h0f};
		live_addr = 16'hbeef;
		live_seg = 8'h5a;
		live_bus.cs_n = 5'h1e;
		live_bus.bhe_n = 1'b0;
		ext_access = 1'b1;
		tick(1);
		ext_access = 1'b0;
		live_addr = 16'h0000;
		live_seg = 8'h00;
		live_bus.cs_n = 5'h1f;
		live_bus.bhe_n = 1'b1;
		alt_sel = 16'h0001;
		req(idle_word);
		wait_mode(pdn_pkg::MODE_IDLE);
		tick(2);
		chk("p0lo", pin_oe_n.p0[7:0], 8'hff);
		chk("p0hi", {pin_oe_n.p0[15:8], pin_out.p0[15:8]}, 16'h00be);
		chk("p1addr", pin_out.p1, 16'hbeef);
		chk("p4seg", pin_out.p4, 8'h0a | (latch_val.p4 & 8'hf0));
		chk("cs", bus_pins.cs_n, 5'h1e);
		chk("bhe", bus_pins.bhe_n, 1'b0);
		chk("rstoutlo", reset_output_pin, 1'b0);
		live_val.gp[0] = 1'b1;
		live_system_clock_output = 1'b0;
		tick(2);
		chk("altlive", pin_out.gp[0], 1'b1);
		chk("clklive", system_clock_output, 1'b0);
		wake_irq = 1'b1;
		wait_mode(pdn_pkg::MODE_ACTIVE);
		wake_irq = 1'b0;
	endtask

	task automatic t_sleep();
		end_of_initialization_pulse = 1'b1;
		tick(1);
		end_of_initialization_pulse = 1'b0;
		xper_access = 1'b1;
		tick(1);
		xper_access = 1'b0;
		dir_in.gp[1] = 1'b1;
		live_programmable_frequency_output = 1'b1;
		tick(2);
		sleep_mode_cfg = 2'h1;
		req(idle_word);
		wait_mode(pdn_pkg::MODE_SLEEP);
		live_val.gp[0] = 1'b0;
		live_programmable_frequency_output = 1'b0;
		tick(3);
		chk("frozen", pin_out.gp[0], 1'b1);
		chk("fouthold", programmable_frequency_output, 1'b1);
		chk("csoff", bus_pins.cs_n, 5'h1f);
		chk("inpin", pin_oe_n.gp[1], 1'b1);
		chk("periph", periph_clk_en, 1'b0);
		chk("rstouthi", reset_output_pin, 1'b1);
		wake_irq = 1'b1;
		wait_mode(pdn_pkg::MODE_ACTIVE);
		wake_irq = 1'b0;
		// Reserved code acts as idle; a falling NMI line ends idle
		sleep_mode_cfg = 2'h2;
		fail = 1'b0;
		tick(12);
		req(idle_word);
		wait_mode(pdn_pkg::MODE_IDLE);
		fail = 1'b1;
		wait_mode(pdn_pkg::MODE_ACTIVE);
		// Sleep with the clock source stopped as well
		sleep_mode_cfg = 2'h3;
		req(idle_word);
		wait_mode(pdn_pkg::MODE_SLEEP);
		chk("oscoff", osc_run, 1'b0);
		wake_irq = 1'b1;
		wait_mode(pdn_pkg::MODE_ACTIVE);
		wake_irq = 1'b0;
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Main sequence
	initial begin
		{instr_valid, instr_done, wake_irq, bus_busy, ext_access, xper_access} = 6'h00;
		{sys2_we, end_of_initialization_pulse, flag_clear, fail, rst_req, live_programmable_frequency_output} = 6'h00;
		instr_word = 32'h0000_0000;
		sleep_mode_cfg = 2'h0;
		sys2_power_down_pin_rtc_control = 2'h0;
		live_addr = 16'h0000;
		live_seg = 8'h00;
		alt_sel = 16'h0000;
		live_system_clock_output = 1'b1;
		lag = 4'h2;
		live_bus = 9'h0ff;
		bus_cfg = '0;
		live_val = '0;
		live_oe_n = '0;
		dir_in = '0;
		latch_val = {16'h1234, 16'h5678, 8'h9a, 16'ha5c3};
		rst = 1'b1;
		tick(12);
		rst = 1'b0;
		tick(1);
		t_reset();
		t_refuse();
		t_power_down_pin_rtc_control();
		t_pdown(2'h2);
		t_pdown(2'h1);
		t_idle();
		t_sleep();
		give_verdict();
	end
endmodule
